// [pulse_pair_decoder.sv]
// Decided for this implementation: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
//Behaviour
//- Serial delay line, length 1 to 63
//- Delay line shifts every 1 us tick
//- X channel: twelve stage delay
//- Y channel: thirty stage delay
//- Inverted channel drives weights two, sixteen
//- Encode pulses clear the delay line
//- Decode only on delayed-live coincidence
//- Decode feeds AGC, ident, dead time, latches
//- Dead time holds delay line reset
//- Dead time not retriggerable, gated by search enable
//- Search enable low blocks dead-time trigger
//- Dead time resets line; complement flags valid
//- Latches capture on strobe, clear when low
//- Four-bit stage counts or loads
//- Either count enable low holds value in count mode
//- Terminal count at fifteen with trickle
//- Counter clear overrides everything
//- Data clear releases counters and latches
//- Channel read low keeps count mode
//- Chain counts each 1 us to 2048
//- Latch strobe never disturbs the count
//- Stage carry enables next stage
module pulse_pair_decoder
	import pulse_pair_pkg::*;
#(
	parameter int unsigned TICK_DIV = TICK_CYCLES
)(
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// AHB-Lite slave
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic hreadyout_o,
	output logic hresp_o,
	output logic [31:0] hrdata_o,
	// Receiver video and channel pins
	input wire logic rx_video_i,
	input wire logic [11:0] chan_data_i,
	// Decode destinations
	output logic agc_sample_o,
	output logic ident_trigger_o,
	output logic dead_time_o,
	output logic valid_decode_n_o,
	output logic count_end_interrupt_o
);
	// Bus state
	logic wr_pend_q; // Write waiting for data phase
	logic [7:0] wr_ofs_q; // Latched write offset
	logic [4:0] ctrl_q; // Control bits
	logic encode_q; // Encode strobe
	// Timebase
	logic [7:0] tick_cnt_q;
	logic tick_q; // One cycle each microsecond
	// Pin synchronisers
	logic [1:0] video_sync_q;
	logic [11:0] chan_meta_q;
	logic [11:0] chan_sync_q;
	logic video_prev_q; // For edge detect
	logic pend_q; // Pulse waiting for a tick
	// Delay line
	logic [DELAY_STAGES-1:0] line_q;
	logic [5:0] length_ctl; // Binary-weighted length
	logic tap; // Delayed first pulse
	logic decode; // Coincidence result
	// Dead time
	logic [6:0] dead_cnt_q;
	logic dead_active;
	logic line_reset;
	// Latches and strobe
	logic read_prev_q;
	logic strobe;
	logic [5:0] latch_lo_q;
	logic [5:0] latch_hi_q;
	// Counter chain
	// One interface per stage carries its controls and outputs
	range_stage_if stg[STAGES] ();
	logic [11:0] count_val;
	// Bus decode
	logic addr_ok;
	logic [31:0] rd_word;

	// Only the low 256 bytes decode; upper address bits must be zero
	// for both the read mux and the write capture, so one helper serves both
	function automatic logic in_window(input logic [31:0] addr);
		return addr[31:8] == 24'h000000;
	endfunction

	// Control aliases
	logic chan_x;
	logic search_en;
	logic data_clear;
	logic chan_read;
	assign chan_x = ctrl_q[CTRL_CHAN_X];
	assign search_en = ctrl_q[CTRL_SEARCH];
	assign data_clear = ctrl_q[CTRL_CLEAR];
	assign chan_read = ctrl_q[CTRL_READ];

	// Divide the core clock down to a 1 us tick
	// Free running from reset, so the tick phase is fixed and every 1 us
	// consumer (line, dead time, counters) advances on the same edge
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			tick_cnt_q <= 8'h00;
			tick_q <= 1'b0;
		end else if (tick_cnt_q == 8'(TICK_DIV - 1)) begin
			tick_cnt_q <= 8'h00;
			tick_q <= 1'b1;
		end else begin
			tick_cnt_q <= tick_cnt_q + 8'h01;
			tick_q <= 1'b0;
		end
	end

	// Two-stage synchronisers on the pins
	// Video and channel pins come from outside the core clock domain;
	// channel lines are static, so a torn word lasts one tick at most
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			video_sync_q <= 2'b00;
			chan_meta_q <= 12'h000;
			chan_sync_q <= 12'h000;
		end else begin
			video_sync_q <= {video_sync_q[0], rx_video_i};
			chan_meta_q <= chan_data_i;
			chan_sync_q <= chan_meta_q;
		end
	end

	// Rising edge of the synced video held until the next tick
	// The pending flag bridges the gap between a short edge and the tick,
	// so a pulse that ends before the tick still enters the line
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			video_prev_q <= 1'b0;
			pend_q <= 1'b0;
		end else begin
			video_prev_q <= video_sync_q[1];
			if (video_sync_q[1] && !video_prev_q) begin
				pend_q <= 1'b1; // Edge wins over tick
			end else if (tick_q || line_reset) begin
				pend_q <= 1'b0;
			end
		end
	end

	// Length weights: inverted channel on two and sixteen
	// X gives 4 + 8 = 12 stages, Y adds 2 + 16 for 30
	// The other weights are tied, so no other length can be selected here
	assign length_ctl = {WEIGHT_THIRTYTWO, ~chan_x, WEIGHT_EIGHT, WEIGHT_FOUR, ~chan_x, WEIGHT_ONE};

	// Tap after length stages; zero length is read as one
	// The full 64 stage line is kept so any programmed length can be tapped;
	// the unused upper stages cost flops but keep the tap logic uniform
	assign tap = (length_ctl == 6'h00) ? line_q[0] : line_q[length_ctl - 6'h01];

	// Encode or dead time hold the line at zero
	// A held line cannot carry an echo into a late coincidence
	assign line_reset = encode_q || dead_active;

	// Serial-in serial-out shift on each tick
	// Reset wins over the shift, so a pulse arriving on a held tick is dropped;
	// this is what keeps echoes out during dead time
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			line_q <= '0;
		end else if (line_reset) begin
			line_q <= '0;
		end else if (tick_q) begin
			line_q <= {line_q[DELAY_STAGES-2:0], pend_q};
		end
	end

	// Coincidence of delayed and live pulse, once per tick
	// Sampling the live video only on the tick makes the decode one cycle wide,
	// however long the second pulse stays high
	assign decode = tick_q && tap && video_sync_q[1] && !line_reset;

	// Dead time counter, loaded by qualified decodes outside dead time
	// Search enable low doubles as the reset input, so a new epoch never
	// starts with the decoder still shut down
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			dead_cnt_q <= 7'h00;
		end else if (decode && search_en) begin
			dead_cnt_q <= DEAD_TICKS;
		end else if (!search_en) begin
			dead_cnt_q <= 7'h00; // Held off before search
		end else if (tick_q && dead_cnt_q != 7'h00) begin
			dead_cnt_q <= dead_cnt_q - 7'h01;
		end
	end
	assign dead_active = (dead_cnt_q != 7'h00);

	// Registered decode outputs; valid flag is the complement
	// All outputs come straight from flops; dead time lags its counter a cycle
	// Valid reads high whenever the decoder is free to accept a pair
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			agc_sample_o <= 1'b0;
			ident_trigger_o <= 1'b0;
			dead_time_o <= 1'b0;
			valid_decode_n_o <= 1'b1;
		end else begin
			agc_sample_o <= decode;
			ident_trigger_o <= decode;
			dead_time_o <= dead_active;
			valid_decode_n_o <= !dead_active;
		end
	end

	// Latch strobe from decodes or channel read edge
	// Only the rising edge of channel read strobes, so a long read is one capture
	assign strobe = decode || (chan_read && !read_prev_q);

	// Capture latches; data clear low empties them
	// Clear wins over a strobe in the same cycle: the clear is a level reset
	// The strobe only copies the count, the counters never see it
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			read_prev_q <= 1'b0;
			latch_lo_q <= 6'h00;
			latch_hi_q <= 6'h00;
		end else begin
			read_prev_q <= chan_read;
			if (!data_clear) begin
				latch_lo_q <= 6'h00;
				latch_hi_q <= 6'h00;
			end else if (strobe) begin
				latch_lo_q <= count_val[5:0]; // Samples only
				latch_hi_q <= count_val[11:6];
			end
		end
	end

	// Counter chain, each stage enabled by the one below
	// Carry is a combinational enable, so the whole chain moves on one edge
	// and no stage ever lags the one below it
	for (genvar i = 0; i < STAGES; i++) begin : g_stage
		assign stg[i].adv = tick_q;
		assign stg[i].parallel_load_n = !chan_read;
		assign stg[i].count_enable_parallel = 1'b1;
		assign stg[i].clear_n = data_clear;
		assign stg[i].load = chan_sync_q[i*STAGE_W +: STAGE_W];
		if (i == 0) begin : g_first
			assign stg[i].count_enable_trickle = 1'b1;
		end else begin : g_next
			assign stg[i].count_enable_trickle = stg[i-1].terminal_count;
		end
		assign count_val[i*STAGE_W +: STAGE_W] = stg[i].q;
		range_counter_stage u_stage (
			.core_clk_i(core_clk_i),
			.rst_i(rst_i),
			.st(stg[i])
		);
	end

	// End of count when top stage reaches eight
	// Bit eleven is the top stage's weight-eight output: 256 x 8 = 2048 ticks
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			count_end_interrupt_o <= 1'b0;
		end else begin
			count_end_interrupt_o <= count_val[11]; // 2048 ticks
		end
	end

	// Bus address phase check
	assign addr_ok = hsel_i && htrans_i[1] && hready_i;

	// Read mux; unmapped offsets read zero
	// Decoded from the address phase; the value is registered for the data phase
	// Status bits are live levels, so a read sees the state at its address phase
	always_comb begin
		rd_word = 32'h0000_0000;
		unique case (haddr_i[7:0])
			CTRL_OFS: rd_word[4:0] = ctrl_q;
			STATUS_OFS: begin
				rd_word[STAT_VALID] = !dead_active;
				rd_word[STAT_DEAD] = dead_active;
				rd_word[STAT_END] = count_val[11];
				rd_word[STAT_DELAYED] = tap;
			end
			COUNT_OFS: rd_word[11:0] = count_val;
			LATCH_OFS: rd_word[11:0] = {latch_hi_q, latch_lo_q};
			default: rd_word = 32'h0000_0000;
		endcase
		if (!in_window(haddr_i)) begin
			rd_word = 32'h0000_0000;
		end
	end

	// Always ready, always OKAY; read data registered for the data phase
	// Zero wait states: every register is a flop that can be read at any time,
	// so the slave never has a reason to stretch a transfer
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			hreadyout_o <= 1'b1;
			hresp_o <= 1'b0;
			hrdata_o <= 32'h0000_0000;
		end else begin
			hreadyout_o <= 1'b1;
			hresp_o <= 1'b0;
			if (addr_ok && !hwrite_i) begin
				hrdata_o <= rd_word;
			end
		end
	end

	// Write address capture
	// The offset is held for the data phase, when hwdata arrives
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			wr_pend_q <= 1'b0;
			wr_ofs_q <= 8'h00;
		end else begin
			wr_pend_q <= addr_ok && hwrite_i && in_window(haddr_i);
			wr_ofs_q <= haddr_i[7:0];
		end
	end

	// Control write in data phase; encode bit self clears
	// Encode is not stored: it reads back zero and pulses the line reset once,
	// so two writes give the controller its two encode pulses
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl_q <= CTRL_RESET;
			encode_q <= 1'b0;
		end else if (wr_pend_q && wr_ofs_q == CTRL_OFS) begin
			ctrl_q <= hwdata_i[4:0] & 5'h1D;
			encode_q <= hwdata_i[CTRL_ENCODE];
		end else begin
			encode_q <= 1'b0;
		end
	end
endmodule

// [pulse_pair_pkg.sv]
package pulse_pair_pkg;
	// Timebase
	localparam int unsigned CLK_PERIOD_NS = 8;
	localparam int unsigned TICK_PERIOD_NS = 1000;
	localparam int unsigned TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
	// Dead time in 1 us ticks
	localparam int unsigned DEAD_TIME_US = 60;
	localparam logic [6:0] DEAD_TICKS = 7'(DEAD_TIME_US);
	// Delay line lengths
	localparam int unsigned DELAY_STAGES = 64;
	localparam int unsigned LEN_X = 12;
	localparam int unsigned LEN_Y = 30;
	// Fixed length weights
	localparam logic WEIGHT_ONE = 1'b0;
	localparam logic WEIGHT_FOUR = 1'b1;
	localparam logic WEIGHT_EIGHT = 1'b1;
	localparam logic WEIGHT_THIRTYTWO = 1'b0;
	// Register byte offsets
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] COUNT_OFS = 8'h08;
	localparam logic [7:0] LATCH_OFS = 8'h0C;
	// Control fields
	localparam int unsigned CTRL_CHAN_X = 0;
	localparam int unsigned CTRL_ENCODE = 1;
	localparam int unsigned CTRL_SEARCH = 2;
	localparam int unsigned CTRL_CLEAR = 3;
	localparam int unsigned CTRL_READ = 4;
	localparam logic [4:0] CTRL_RESET = 5'h01;
	// Status fields
	localparam int unsigned STAT_VALID = 0;
	localparam int unsigned STAT_DEAD = 1;
	localparam int unsigned STAT_END = 2;
	localparam int unsigned STAT_DELAYED = 3;
	// Counter stage
	localparam int unsigned STAGE_W = 4;
	localparam int unsigned STAGES = 3;
	localparam logic [3:0] STAGE_TOP = 4'hF;
endpackage

// [pulse_pair_props.sv]
`timescale 1ns/1ns
module pulse_pair_props #(
	parameter int unsigned TICK_DIV = 125
)(
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// Bus
	input wire logic hsel_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic hreadyout_o,
	input wire logic hresp_o,
	input wire logic [31:0] hrdata_o,
	// Decode outputs
	input wire logic agc_sample_o,
	input wire logic ident_trigger_o,
	input wire logic dead_time_o,
	input wire logic valid_decode_n_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	// Cycles spent in dead time, kept at its fall
	logic [15:0] dead_q;
	// Counter, cleared whenever dead time is off
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			dead_q <= 16'h0000;
		end else begin
			dead_q <= dead_time_o ? dead_q + 16'h0001 : 16'h0000;
		end
	end
	a_ready_high: assert property (hreadyout_o) else $error("wait state seen");
	a_resp_okay: assert property (!hresp_o) else $error("error response seen");
	a_decode_fanout: assert property (agc_sample_o == ident_trigger_o)
		else $error("decode outputs differ");
	a_decode_once: assert property (agc_sample_o |=> !agc_sample_o)
		else $error("decode pulse too long");
	a_dead_cause: assert property ($rose(dead_time_o) |-> $past(agc_sample_o))
		else $error("dead time without decode");
	a_valid_compl: assert property (valid_decode_n_o != dead_time_o)
		else $error("valid not complement of dead");
	a_dead_hold: assert property ($rose(dead_time_o) |=> dead_time_o [*8])
		else $error("dead time dropped early");
	a_dead_length: assert property ($fell(dead_time_o) |->
		dead_q >= 59 * TICK_DIV && dead_q <= 61 * TICK_DIV)
		else $error("dead time length wrong");
	a_rdata_hold: assert property (!(hsel_i && htrans_i[1] && !hwrite_i) |=> $stable(hrdata_o))
		else $error("read data moved");
endmodule
bind pulse_pair_decoder pulse_pair_props #(.TICK_DIV(TICK_DIV)) i_pulse_pair_props (.core_clk_i(core_clk_i),
	.rst_i(rst_i), .hsel_i(hsel_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hreadyout_o(hreadyout_o),
	.hresp_o(hresp_o), .hrdata_o(hrdata_o), .agc_sample_o(agc_sample_o), .ident_trigger_o(ident_trigger_o),
	.dead_time_o(dead_time_o), .valid_decode_n_o(valid_decode_n_o));

// [range_counter_stage.sv]
`timescale 1ns/1ns
module range_counter_stage
	import pulse_pair_pkg::*;
(
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// Control and data
	range_stage_if.stage st
);
	logic [3:0] q_q; // Stage value

	// Clear first, then load, then count, else hold
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			q_q <= 4'h0;
		end else if (!st.clear_n) begin
			q_q <= 4'h0;
		end else if (st.adv && !st.parallel_load_n) begin
			q_q <= st.load;
		end else if (st.adv && st.count_enable_parallel && st.count_enable_trickle) begin
			q_q <= q_q + 4'h1;
		end
		// Any enable low keeps the value in count mode
	end

	assign st.q = q_q;
	// Carry only while trickle enabled at top count
	assign st.terminal_count = st.count_enable_trickle && (q_q == STAGE_TOP);
endmodule

// [range_stage_if.sv]
`timescale 1ns/1ns
interface range_stage_if;
	logic adv; // 1 us tick
	logic parallel_load_n;
	logic count_enable_parallel;
	logic count_enable_trickle;
	logic clear_n;
	logic [3:0] load;
	logic [3:0] q;
	logic terminal_count;
	modport stage (input adv, parallel_load_n, count_enable_parallel, count_enable_trickle,
		clear_n, load, output q, terminal_count);
	modport ctrl (output adv, parallel_load_n, count_enable_parallel, count_enable_trickle,
		clear_n, load, input q, terminal_count);
endinterface

// [test_pulse_pair_decoder.sv]
`timescale 1ns/1ns
module test_pulse_pair_decoder;
	import pulse_pair_pkg::*;
	// Short tick keeps the run brief
	localparam int unsigned TD = 2;
	logic core_clk_i, rst_i, hsel_i, hwrite_i, hreadyout_o, hresp_o, rx_video_i;
	logic agc_sample_o, ident_trigger_o, dead_time_o, valid_decode_n_o, count_end_interrupt_o;
	logic [1:0] htrans_i;
	logic [31:0] haddr_i, hwdata_i, hrdata_o, rd, c1;
	logic [11:0] chan_data_i;
	int n_mismatch, total_checks, n_dec, n0, i;
	// Trial table: control, spacing in ticks, decodes, dead time
	logic [4:0] t_ctrl [5] = '{5'h0D, 5'h0D, 5'h0C, 5'h0C, 5'h09};
	int t_gap [5] = '{12, 30, 30, 12, 12};
	logic t_dec [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
	logic t_dead [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
	initial begin
		core_clk_i = 1'b0;
		forever #4 core_clk_i = ~core_clk_i;
	end
	pulse_pair_decoder #(.TICK_DIV(TD)) i_pulse_pair_decoder (.core_clk_i(core_clk_i), .rst_i(rst_i),
		.hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2),
		.hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
		.hrdata_o(hrdata_o), .rx_video_i(rx_video_i), .chan_data_i(chan_data_i), .agc_sample_o(agc_sample_o),
		.ident_trigger_o(ident_trigger_o), .dead_time_o(dead_time_o), .valid_decode_n_o(valid_decode_n_o),
		.count_end_interrupt_o(count_end_interrupt_o));
	video_source i_video_source (.core_clk_i(core_clk_i), .rx_video_o(rx_video_i));
	// Decode pulse tally; both fanout outputs must pulse together
	always @(posedge core_clk_i) if (agc_sample_o === 1'b1 && ident_trigger_o === 1'b1) n_dec <= n_dec + 1;
	task close_out;
		if (n_mismatch == 0 && total_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Bounded wait for hready at a rising edge
	task wait_rdy;
		int k;
		k = 0;
		do begin
			@(posedge core_clk_i);
			k++;
		end while (hreadyout_o !== 1'b1 && k < 20);
		if (hreadyout_o !== 1'b1) begin
			n_mismatch++;
			close_out();
		end
	endtask
	// One single word transfer; read data lands in rd
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk_i);
		hsel_i <= 1'b1;
		htrans_i <= 2'h2;
		haddr_i <= {24'h000000, a};
		hwrite_i <= w;
		wait_rdy();
		hsel_i <= 1'b0;
		htrans_i <= 2'h0;
		hwdata_i <= d;
		wait_rdy();
		rd = hrdata_o;
	endtask
	// Overall limit against a hang
	initial begin
		repeat (100000) @(posedge core_clk_i);
		n_mismatch++;
		close_out();
	end
	initial begin
		{rst_i, hsel_i, htrans_i, hwrite_i, haddr_i, hwdata_i} = {1'b1, 68'h0};
		chan_data_i = 12'hA5C;
		{n_mismatch, total_checks, n_dec} = {32'h0, 32'h0, 32'h0};
		repeat (3) @(posedge core_clk_i);
		rst_i <= 1'b0;
		bus(1'b0, CTRL_OFS, 32'h0);
		chk(rd, 32'h1);
		bus(1'b1, STATUS_OFS, 32'hF);
		bus(1'b0, STATUS_OFS, 32'h0);
		chk(rd, 32'h1);
		bus(1'b0, 8'h40, 32'h0);
		chk(rd, 32'h0);
		// Run the chain; sixteen ticks cross a stage carry
		bus(1'b1, CTRL_OFS, 32'h9);
		bus(1'b0, COUNT_OFS, 32'h0);
		c1 = rd;
		// Reads sixteen ticks apart, whatever the tick phase
		repeat (16 * TD - 3) @(posedge core_clk_i);
		bus(1'b0, COUNT_OFS, 32'h0);
		chk(rd - c1, 32'd16);
		// Fifteen range epochs, each opened the way the controller does
		for (int e = 0; e < 15; e++) begin
			repeat (2) bus(1'b1, CTRL_OFS, 32'h3); // Two encodes, search and clear low
			bus(1'b0, COUNT_OFS, 32'h0);
			chk(rd, 32'h0);
			repeat (53 * TD) @(posedge core_clk_i);
			bus(1'b1, CTRL_OFS, 32'hD); // Search and clear rise together
			for (i = 0; i < 2100 * TD && count_end_interrupt_o !== 1'b1; i++) @(posedge core_clk_i);
			chk(count_end_interrupt_o, 1'b1);
			if (count_end_interrupt_o !== 1'b1) close_out();
			bus(1'b0, COUNT_OFS, 32'h0);
			chk(rd & 32'hF00, 32'h800);
		end
		// Channel read after the fifteenth count
		bus(1'b1, CTRL_OFS, 32'h19);
		repeat (4 * TD) @(posedge core_clk_i);
		bus(1'b0, COUNT_OFS, 32'h0);
		chk(rd, 32'hA5C);
		bus(1'b0, LATCH_OFS, 32'h0);
		chk(rd & 32'hF00, 32'h800);
		bus(1'b1, CTRL_OFS, 32'h11);
		bus(1'b0, LATCH_OFS, 32'h0);
		chk(rd, 32'h0);
		// Pulse pairs over both channels, right and wrong spacing
		for (int t = 0; t < 5; t++) begin
			bus(1'b1, CTRL_OFS, {27'h0, t_ctrl[t]} | 32'h2);
			bus(1'b0, CTRL_OFS, 32'h0);
			chk(rd, {27'h0, t_ctrl[t]});
			n0 = n_dec;
			i_video_source.send_pair(t_gap[t] * TD, 3 * TD);
			repeat (20 * TD) @(posedge core_clk_i);
			chk(n_dec - n0, t_dec[t]);
			chk(dead_time_o, t_dead[t]);
			chk(valid_decode_n_o, !t_dead[t]);
			bus(1'b0, STATUS_OFS, 32'h0);
			chk(rd[1:0], t_dead[t] ? 2'b10 : 2'b01);
			for (i = 0; i < 80 * TD && dead_time_o !== 1'b0; i++) @(posedge core_clk_i);
			chk(dead_time_o, 1'b0);
			if (dead_time_o !== 1'b0) close_out();
		end
		close_out();
	end
endmodule

// [video_source.sv]
`timescale 1ns/1ns
module video_source (
	// Clock
	input wire logic core_clk_i,
	// Receiver video
	output logic rx_video_o
);
	// Quiet line until a reply comes
	initial rx_video_o = 1'b0;
	// Two pulses, leading edges gap cycles apart
	task automatic send_pair(input int gap, input int width);
		repeat (2) begin
			@(posedge core_clk_i);
			rx_video_o <= 1'b1;
			repeat (width) @(posedge core_clk_i);
			rx_video_o <= 1'b0;
			repeat (gap - width - 1) @(posedge core_clk_i);
		end
	endtask
endmodule
